// ==== rtl/pmcg_top.sv ====
// Power-management clock gating and software reset control word.
// Assumes a host write port and clock-enable style gating downstream.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - accumulator clock auto-gated unless its force bit is set, then forced on.
// - accumulator memory clock auto-gated unless its force bit is set.
// - converter clock enable bit feeds clock to 8-bit temperature and voltage converters.
// - wake sampling starts only when the always-on wake sampling option is on.
// - GPIO clock enable gates GPIO clock; lines usable with reset bit high.
// - GPIO reset is active low; zero holds port in reset.
// - de-bounce filter passes a level after two equal samples on de-bounce ticks.
// - de-bounce clock enable also gates the LED blink tick.
// - de-bounce and LED ticks come from the kilohertz divider, host configures it.
// - de-bounce reset active low; filter runs only with both bits high.
// - slow divider enable bit runs the divider, one tick every supplied divide value plus one cycles.
// - four reset bits reset transmitter, receiver, host interface and controller.
// - each reset bit active low; block held in reset while zero.
// - always-on wake logic is untouched by software reset.
// - system clock selector value 01 forces the crystal clock.
module pmcg_top (
  input  wire logic                                i_clk,
  input  wire logic                                i_reset,
  input  wire logic                                i_wr_en,
  input  wire logic [7:0]                          i_addr,
  input  wire logic [31:0]                         i_wr_data,
  output logic      [31:0]                         o_rd_data,
  input  wire logic [pmcg_pkg::DIV_W-1:0]          i_slow_divider_value,
  input  wire logic [1:0]                          i_sys_clk_select,
  input  wire logic                                i_accum_req,
  input  wire logic                                i_accum_mem_req,
  input  wire logic                                i_wake,
  input  wire logic                                i_wake_sample_enable,
  input  wire logic                                i_sample_done,
  input  wire logic [pmcg_pkg::GPIO_LINES-1:0]     i_gpio_in,
  output logic                                     o_accum_clk_en,
  output logic                                     o_accum_mem_clk_en,
  output logic                                     o_converter_clk_en,
  output logic                                     o_wake_sample_start,
  output logic                                     o_gpio_clk_en,
  output logic                                     o_gpio_reset_n,
  output logic                                     o_debounce_tick,
  output logic                                     o_led_tick,
  output logic      [pmcg_pkg::GPIO_LINES-1:0]     o_gpio_clean,
  output logic                                     o_tx_reset_n,
  output logic                                     o_rx_reset_n,
  output logic                                     o_host_reset_n,
  output logic                                     o_power_controller_reset_n,
  output logic                                     o_sys_clk_crystal
);
  // ==========================================================================
  // Control register
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    rd_data_nxt = (i_addr == pmcg_pkg::CTRL0_OFFSET) ? ctrl_r : 32'h0000_0000;
    if (i_wr_en && (i_addr == pmcg_pkg::CTRL0_OFFSET)) begin
      ctrl_nxt = i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r    <= pmcg_pkg::CTRL0_RESET;
      rd_data_r <= 32'h0000_0000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  logic pmc_rst;
  assign pmc_rst = i_reset || !ctrl_r[pmcg_pkg::SW_RESET_PMC_BIT];

  // ==========================================================================
  // Kilohertz divider
  logic [pmcg_pkg::DIV_W-1:0] div_cnt_r;
  logic [pmcg_pkg::DIV_W-1:0] div_cnt_nxt;
  logic                       div_tick_r;
  logic                       div_tick_nxt;

  always_comb begin
    div_cnt_nxt  = div_cnt_r;
    div_tick_nxt = 1'b0;
    if (ctrl_r[pmcg_pkg::SLOW_DIVIDER_EN_BIT]) begin
      if (div_cnt_r >= i_slow_divider_value) begin
        div_cnt_nxt  = '0;
        div_tick_nxt = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 1'b1;
      end
    end else begin
      div_cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (pmc_rst) begin
      div_cnt_r  <= '0;
      div_tick_r <= 1'b0;
    end else begin
      div_cnt_r  <= div_cnt_nxt;
      div_tick_r <= div_tick_nxt;
    end
  end

  // ==========================================================================
  // Wake-up sampling, kept out of software reset
  pmcg_pkg::pmcg_wake_t wk_r;
  pmcg_pkg::pmcg_wake_t wk_nxt;
  logic                 wk_start_nxt;

  always_comb begin
    wk_nxt       = wk_r;
    wk_start_nxt = 1'b0;
    case (wk_r)
      pmcg_pkg::PMCG_WK_IDLE: begin
        if (i_wake && i_wake_sample_enable) begin
          wk_nxt       = pmcg_pkg::PMCG_WK_SAMPLE;
          wk_start_nxt = 1'b1;
        end
      end
      pmcg_pkg::PMCG_WK_SAMPLE: begin
        if (i_sample_done) begin
          wk_nxt = pmcg_pkg::PMCG_WK_IDLE;
        end
      end
      default: wk_nxt = pmcg_pkg::PMCG_WK_IDLE;
    endcase
  end

  // ==========================================================================
  // Registered enables and resets
  logic                                o_accum_clk_en_nxt;
  logic                                o_accum_mem_clk_en_nxt;
  logic                                o_converter_clk_en_nxt;
  logic                                o_debounce_tick_nxt;
  logic                                o_led_tick_nxt;
  logic [pmcg_pkg::GPIO_LINES-1:0]     o_gpio_clean_nxt;
  pmcg_dbnc_if                         dbnc ();

  always_comb begin
    o_accum_clk_en_nxt     = ctrl_r[pmcg_pkg::ACCUM_CLK_FORCE_BIT] || i_accum_req;
    o_accum_mem_clk_en_nxt = ctrl_r[pmcg_pkg::ACCUM_MEM_CLK_FORCE_BIT]
                             || i_accum_mem_req;
    o_converter_clk_en_nxt = ctrl_r[pmcg_pkg::CONVERTER_CLK_EN_BIT]
                             || (wk_r == pmcg_pkg::PMCG_WK_SAMPLE);
    o_debounce_tick_nxt    = div_tick_r && ctrl_r[pmcg_pkg::DEBOUNCE_CLK_EN_BIT]
                             && ctrl_r[pmcg_pkg::DEBOUNCE_RESET_N_BIT];
    o_led_tick_nxt         = div_tick_r && ctrl_r[pmcg_pkg::DEBOUNCE_CLK_EN_BIT];
    o_gpio_clean_nxt       = dbnc.clean;
  end

  assign dbnc.tick = o_debounce_tick;
  assign dbnc.hold = pmc_rst || !ctrl_r[pmcg_pkg::DEBOUNCE_RESET_N_BIT];
  assign dbnc.raw  = i_gpio_in;

  pmcg_debounce u_debounce (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .dbnc    (dbnc)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wk_r                <= pmcg_pkg::PMCG_WK_IDLE;
      o_wake_sample_start <= 1'b0;
    end else begin
      wk_r                <= wk_nxt;
      o_wake_sample_start <= wk_start_nxt;
    end
  end

  // Enables only change at edges, so gated clocks never see a cut pulse
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_accum_clk_en             <= 1'b0;
      o_accum_mem_clk_en         <= 1'b0;
      o_converter_clk_en         <= 1'b0;
      o_gpio_clk_en              <= 1'b0;
      o_gpio_reset_n             <= 1'b0;
      o_debounce_tick            <= 1'b0;
      o_led_tick                 <= 1'b0;
      o_gpio_clean               <= '0;
      o_tx_reset_n               <= 1'b0;
      o_rx_reset_n               <= 1'b0;
      o_host_reset_n             <= 1'b0;
      o_power_controller_reset_n <= 1'b0;
      o_sys_clk_crystal          <= 1'b0;
    end else begin
      o_accum_clk_en             <= o_accum_clk_en_nxt;
      o_accum_mem_clk_en         <= o_accum_mem_clk_en_nxt;
      o_converter_clk_en         <= o_converter_clk_en_nxt;
      o_gpio_clk_en              <= ctrl_r[pmcg_pkg::GPIO_CLK_EN_BIT];
      o_gpio_reset_n             <= ctrl_r[pmcg_pkg::GPIO_RESET_N_BIT];
      o_debounce_tick            <= o_debounce_tick_nxt;
      o_led_tick                 <= o_led_tick_nxt;
      o_gpio_clean               <= o_gpio_clean_nxt;
      o_tx_reset_n               <= ctrl_r[pmcg_pkg::SW_RESET_TX_BIT];
      o_rx_reset_n               <= ctrl_r[pmcg_pkg::SW_RESET_RX_BIT];
      o_host_reset_n             <= ctrl_r[pmcg_pkg::SW_RESET_HOST_BIT];
      o_power_controller_reset_n <= ctrl_r[pmcg_pkg::SW_RESET_PMC_BIT];
      o_sys_clk_crystal          <= (i_sys_clk_select == pmcg_pkg::SYS_CLK_CRYSTAL);
    end
  end

  assign o_rd_data = rd_data_r;

  // ==========================================================================
  // Checks
  accum_force_on_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctrl_r[pmcg_pkg::ACCUM_CLK_FORCE_BIT] |=> o_accum_clk_en)
    else $error("accumulator clock not forced on");
  accum_auto_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!ctrl_r[pmcg_pkg::ACCUM_CLK_FORCE_BIT] && !i_accum_req) |=> !o_accum_clk_en)
    else $error("accumulator clock on without force or request");
  mem_force_on_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (ctrl_r[pmcg_pkg::ACCUM_MEM_CLK_FORCE_BIT] || i_accum_mem_req) |=> o_accum_mem_clk_en)
    else $error("accumulator memory clock not enabled");
  conv_clk_on_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ctrl_r[pmcg_pkg::CONVERTER_CLK_EN_BIT] |=> o_converter_clk_en)
    else $error("converter clock not enabled");
  wake_gated_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_wake_sample_start |-> ($past(i_wake_sample_enable) && $past(i_wake)))
    else $error("wake sampling started without its option");
  gpio_rst_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrl_r[pmcg_pkg::GPIO_RESET_N_BIT] |=> !o_gpio_reset_n)
    else $error("GPIO not held in reset");
  gpio_clk_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_gpio_clk_en |-> $past(ctrl_r[pmcg_pkg::GPIO_CLK_EN_BIT]))
    else $error("GPIO clock enabled without its bit");
  dbnc_tick_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_debounce_tick |-> ($past(ctrl_r[pmcg_pkg::DEBOUNCE_CLK_EN_BIT], 1)
                         && $past(ctrl_r[pmcg_pkg::DEBOUNCE_RESET_N_BIT], 1)))
    else $error("de-bounce tick without enable and reset release");
  led_tick_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_led_tick |-> $past(ctrl_r[pmcg_pkg::DEBOUNCE_CLK_EN_BIT]))
    else $error("LED tick without de-bounce clock enable");
  div_stopped_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrl_r[pmcg_pkg::SLOW_DIVIDER_EN_BIT] |=> !div_tick_r)
    else $error("divider ticked while disabled");
  rx_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !ctrl_r[pmcg_pkg::SW_RESET_RX_BIT] |=> !o_rx_reset_n)
    else $error("receiver not held in reset");
  sys_crystal_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_sys_clk_select == pmcg_pkg::SYS_CLK_CRYSTAL) |=> o_sys_clk_crystal)
    else $error("crystal clock not selected");

  full_reset_c: cover property (@(posedge i_clk) disable iff (i_reset)
    !o_tx_reset_n && !o_rx_reset_n && !o_host_reset_n && !o_power_controller_reset_n);
  wake_sample_c: cover property (@(posedge i_clk) disable iff (i_reset)
    o_wake_sample_start ##[1:20] !o_converter_clk_en);
  debounce_c: cover property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_gpio_clean[0]));
endmodule : pmcg_top
`default_nettype wire

// ==== rtl/pmcg_pkg.sv ====
// Constants for the power-management clock gate and software reset block.
// Assumes a single 100 MHz clock and a host that writes the control word.
`default_nettype none
package pmcg_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0]  CTRL0_OFFSET = 8'h00;
  localparam logic [31:0] CTRL0_RESET  = 32'hF030_0200;

  // ==========================================================================
  // Field positions
  localparam int ACCUM_CLK_FORCE_BIT     = 6;
  localparam int CONVERTER_CLK_EN_BIT    = 10;
  localparam int ACCUM_MEM_CLK_FORCE_BIT = 15;
  localparam int GPIO_CLK_EN_BIT         = 16;
  localparam int GPIO_RESET_N_BIT        = 17;
  localparam int DEBOUNCE_CLK_EN_BIT     = 18;
  localparam int DEBOUNCE_RESET_N_BIT    = 19;
  localparam int SLOW_DIVIDER_EN_BIT     = 23;
  localparam int SW_RESET_RX_BIT         = 28;
  localparam int SW_RESET_TX_BIT         = 29;
  localparam int SW_RESET_HOST_BIT       = 30;
  localparam int SW_RESET_PMC_BIT        = 31;

  // ==========================================================================
  // Widths and encodings
  localparam int         GPIO_LINES      = 9;
  localparam int         DIV_W           = 6;
  localparam logic [1:0] SYS_CLK_CRYSTAL = 2'h1;

  typedef enum logic {PMCG_WK_IDLE, PMCG_WK_SAMPLE} pmcg_wake_t;
endpackage : pmcg_pkg
`default_nettype wire

// ==== rtl/pmcg_dbnc_if.sv ====
// Carrier between the control top and the de-bounce filter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pmcg_dbnc_if;
  logic                            tick;
  logic                            hold;
  logic [pmcg_pkg::GPIO_LINES-1:0] raw;
  logic [pmcg_pkg::GPIO_LINES-1:0] clean;

  modport ctrl (output tick, output hold, output raw, input clean);
  modport filt (input tick, input hold, input raw, output clean);
endinterface : pmcg_dbnc_if
`default_nettype wire

// ==== rtl/pmcg_debounce.sv ====
// GPIO de-bounce filter, one two-sample stage per line.
// Assumes tick is a one-cycle enable and hold is a synchronous clear.
`timescale 1ns/1ps
`default_nettype none
module pmcg_debounce (
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  pmcg_dbnc_if.filt  dbnc
);
  // ==========================================================================
  // Per-line filter
  logic [pmcg_pkg::GPIO_LINES-1:0] sample_r;
  logic [pmcg_pkg::GPIO_LINES-1:0] sample_nxt;
  logic [pmcg_pkg::GPIO_LINES-1:0] clean_r;
  logic [pmcg_pkg::GPIO_LINES-1:0] clean_nxt;

  genvar g;
  generate
    for (g = 0; g < pmcg_pkg::GPIO_LINES; g++) begin : g_line
      always_comb begin
        sample_nxt[g] = sample_r[g];
        clean_nxt[g]  = clean_r[g];
        if (dbnc.hold) begin
          sample_nxt[g] = 1'b0;
          clean_nxt[g]  = 1'b0;
        end else if (dbnc.tick) begin
          sample_nxt[g] = dbnc.raw[g];
          // Level passes only after two equal samples
          if (dbnc.raw[g] == sample_r[g]) begin
            clean_nxt[g] = dbnc.raw[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sample_r <= '0;
      clean_r  <= '0;
    end else begin
      sample_r <= sample_nxt;
      clean_r  <= clean_nxt;
    end
  end

  assign dbnc.clean = clean_r;

  // ==========================================================================
  // Checks
  clean_needs_tick_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ($changed(clean_r) && !$past(dbnc.hold)) |-> $past(dbnc.tick))
    else $error("filtered level changed without a de-bounce tick");
  hold_clears_a: assert property (@(posedge i_clk) disable iff (i_reset)
    dbnc.hold |=> (clean_r == '0))
    else $error("filter output not cleared while held");
endmodule : pmcg_debounce
`default_nettype wire

// ==== verification/pmcg_host_model.sv ====
// Host model: writes and reads the control word, drives the selector inputs.
// Assumes the design samples every input on the rising edge of i_clk.
`timescale 1ns/1ps
`default_nettype none
module pmcg_host_model (
  input  wire logic [31:0]                i_rd_data,
  input  wire logic                       i_clk,
  output logic                            o_wr_en,
  output logic      [7:0]                 o_addr,
  output logic      [31:0]                o_wr_data,
  output logic      [pmcg_pkg::DIV_W-1:0] o_slow_divider_value,
  output logic      [1:0]                 o_sys_clk_select
);
  // ==========================================================================
  // Idle values
  initial begin
    o_wr_en              = 1'b0;
    o_addr               = 8'h00;
    o_wr_data            = 32'h0000_0000;
    o_slow_divider_value = '0;
    o_sys_clk_select     = 2'h0;
  end

  // ==========================================================================
  // Access tasks
  // One-cycle strobe; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_wr_en   <= 1'b1;
    o_addr    <= a;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en   <= 1'b0;
    o_wr_data <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    @(posedge i_clk);
    #1;
    d = i_rd_data;
  endtask : rd

  // Crystal clock first, before any full soft reset
  task automatic sel_crystal();
    @(posedge i_clk);
    o_sys_clk_select <= pmcg_pkg::SYS_CLK_CRYSTAL;
  endtask : sel_crystal

  // Divide value set before the ticks are relied on
  task automatic set_div(input logic [pmcg_pkg::DIV_W-1:0] v);
    @(posedge i_clk);
    o_slow_divider_value <= v;
  endtask : set_div

  // Both accumulator clocks forced before an accumulator read
  task automatic accum_prep();
    wr(8'h00, 32'hF000_8040);
  endtask : accum_prep
endmodule : pmcg_host_model
`default_nettype wire

// ==== verification/power_mgmt_clock_gate_sw_reset_n_bench.sv ====
// Testbench for pmcg_top: control word writes, clock enables, ticks, resets.
// Assumes pmcg_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_clock_gate_sw_reset_n_bench;
  logic i_clk, i_reset, accum_req, mem_req, wake, wake_en, done;
  logic [8:0]  gpio_in;
  logic [8:0]  gpio_clean;
  logic [31:0] rd_data, wr_data, rv;
  logic [7:0]  addr;
  logic [5:0]  div_value;
  logic [1:0]  clk_sel;
  logic wr_en, acc_en, mem_en, conv_en, start, gclk, grst, dbt, led, tx, rx, hst, pmc, xtal;
  int   n_mismatch, checks, cycles, c;
  int   bitpos [5];
  logic [4:0] en;
  logic [3:0] rst_n;
  assign en    = {grst, gclk, conv_en, mem_en, acc_en};
  assign rst_n = {pmc, hst, tx, rx};

  pmcg_host_model host (.i_rd_data(rd_data), .i_clk(i_clk), .o_wr_en(wr_en), .o_addr(addr),
    .o_wr_data(wr_data), .o_slow_divider_value(div_value), .o_sys_clk_select(clk_sel));

  pmcg_top uut (.i_clk(i_clk), .i_reset(i_reset), .i_wr_en(wr_en), .i_addr(addr),
    .i_wr_data(wr_data), .o_rd_data(rd_data), .i_slow_divider_value(div_value),
    .i_sys_clk_select(clk_sel), .i_accum_req(accum_req), .i_accum_mem_req(mem_req),
    .i_wake(wake), .i_wake_sample_enable(wake_en), .i_sample_done(done),
    .i_gpio_in(gpio_in), .o_accum_clk_en(acc_en), .o_accum_mem_clk_en(mem_en),
    .o_converter_clk_en(conv_en), .o_wake_sample_start(start), .o_gpio_clk_en(gclk),
    .o_gpio_reset_n(grst), .o_debounce_tick(dbt), .o_led_tick(led),
    .o_gpio_clean(gpio_clean), .o_tx_reset_n(tx), .o_rx_reset_n(rx), .o_host_reset_n(hst),
    .o_power_controller_reset_n(pmc), .o_sys_clk_crystal(xtal));

  // ==========================================================================
  // Clock, timeout and reporting
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("Error timeout expected end seen %0d cycles", cycles);
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic settle();
    @(posedge i_clk);
    #1;
  endtask : settle

  task automatic count_led(input int n);
    c = 0;
    repeat (n) begin
      settle();
      if (led === 1'b1) c++;
    end
  endtask : count_led

  // ==========================================================================
  // Main sequence
  initial begin
    bitpos = '{6, 15, 10, 16, 17};
    i_reset = 1'b1; accum_req = 1'b0; mem_req = 1'b0; wake = 1'b0; wake_en = 1'b0;
    done = 1'b0; gpio_in = 9'h000; n_mismatch = 0; checks = 0; cycles = 0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    settle();
    chk("sw_reset_n", 32'h0000_000F, {28'h0, rst_n});
    chk("enables", 32'h0000_0000, {27'h0, en});
    chk("crystal", 32'h0000_0000, {31'h0, xtal});
    host.rd(8'h00, rv);
    chk("ctrl reset", pmcg_pkg::CTRL0_RESET, rv);
    host.wr(8'h04, 32'h0000_0000);
    host.rd(8'h04, rv);
    chk("unmapped", 32'h0000_0000, rv);
    host.rd(8'h00, rv);
    chk("ctrl kept", pmcg_pkg::CTRL0_RESET, rv);
    // One control bit at a time reaches its own enable only
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h00, 32'hF000_0000 | (32'h1 << bitpos[i]));
      settle();
      chk("enables", 32'h1 << i, {27'h0, en});
    end
    host.wr(8'h00, 32'hF000_0000);
    accum_req <= 1'b1;
    mem_req   <= 1'b1;
    settle();
    chk("auto gating", 32'h0000_0003, {27'h0, en});
    @(posedge i_clk);
    accum_req <= 1'b0;
    mem_req   <= 1'b0;
    settle();
    chk("auto off", 32'h0000_0000, {27'h0, en});
    host.accum_prep();
    settle();
    chk("accum forced", 32'h0000_0003, {27'h0, en});
    // Divider every cycle, filter and LED ticks on
    host.set_div(6'h00);
    host.wr(8'h00, 32'hF08F_0000);
    repeat (4) settle();
    repeat (8) begin
      settle();
      chk("ticks", 32'h0000_0003, {30'h0, led, dbt});
    end
    @(posedge i_clk);
    gpio_in <= 9'h1A5;
    repeat (8) settle();
    chk("gpio clean", 32'h0000_01A5, {23'h0, gpio_clean});
    @(posedge i_clk);
    gpio_in <= 9'h000;
    @(posedge i_clk);
    gpio_in <= 9'h1A5;
    repeat (6) begin
      settle();
      chk("glitch held", 32'h0000_01A5, {23'h0, gpio_clean});
    end
    host.wr(8'h00, 32'hF087_0000);
    repeat (4) settle();
    chk("filter reset", 32'h0000_0000, {23'h0, gpio_clean});
    chk("led only", 32'h0000_0002, {30'h0, led, dbt});
    host.wr(8'h00, 32'hF083_0000);
    repeat (3) settle();
    count_led(16);
    chk("led gated", 32'd0, 32'(c));
    host.set_div(6'h03);
    host.wr(8'h00, 32'hF08F_0000);
    repeat (6) settle();
    count_led(40);
    chk("tick period", 32'd10, 32'(c));
    host.wr(8'h00, 32'hF00F_0000);
    repeat (3) settle();
    count_led(40);
    chk("divider off", 32'd0, 32'(c));
    // Full and receiver-only soft resets
    host.sel_crystal();
    settle();
    chk("crystal", 32'h0000_0001, {31'h0, xtal});
    host.wr(8'h00, 32'h0000_0000);
    settle();
    chk("sw_reset_n", 32'h0000_0000, {28'h0, rst_n});
    host.wr(8'h00, 32'hF000_0000);
    settle();
    chk("sw_reset_n", 32'h0000_000F, {28'h0, rst_n});
    host.wr(8'h00, 32'hE000_0000);
    settle();
    chk("rx only", 32'h0000_000E, {28'h0, rst_n});
    host.wr(8'h00, 32'hF000_0000);
    settle();
    chk("rx back", 32'h0000_000F, {28'h0, rst_n});
    // Wake sampling, with the soft resets held low
    host.wr(8'h00, 32'h0000_0000);
    @(posedge i_clk);
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    #1;
    chk("no wake start", 32'h0000_0000, {31'h0, start});
    @(posedge i_clk);
    wake_en <= 1'b1;
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    #1;
    chk("wake start", 32'h0000_0001, {31'h0, start});
    settle();
    chk("conv on", 32'h0000_0002, {30'h0, conv_en, start});
    @(posedge i_clk);
    done <= 1'b1;
    @(posedge i_clk);
    done <= 1'b0;
    repeat (4) settle();
    chk("conv off", 32'h0000_0000, {31'h0, conv_en});
    results();
  end
endmodule : power_mgmt_clock_gate_sw_reset_n_bench
`default_nettype wire
